// [dv/cmp_model.sv]
`timescale 1ns/1ns
`default_nettype none
// comparator of the front end; a steady level gives all-ones or all-zeros
module cmp_model (
  input wire logic i_clk,
  input wire logic i_level,
  output logic o_cmp
);
  // registered so the answer never moves in the sampling step
  always_ff @(posedge i_clk) begin
    o_cmp <= i_level;
  end
endmodule
`default_nettype wire

// [dv/sar_ctrl_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module sar_ctrl_chk
  import sar_ctrl_pkg::*;
#(parameter int EMU_CYC = 4) (
  input wire logic I_CLK, I_RSTN, I_CE, I_SEL_N, I_RD_CONV, I_WORD_WIDE, I_MODE_CTRL,
  input wire logic O_BUSY, O_HOLD,
  input wire logic [RES_W-1:0] O_RESULT_OE
);
  localparam int EMU_LO = EMU_CYC - 1;
  localparam int EMU_HI = EMU_CYC + 1;
  localparam int BUSY_HI = EMU_CYC + 14;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  // mode is synchronised, so it must sit still a few cycles before the start
  sequence s_emu_go; (!I_MODE_CTRL)[*4] ##0 $rose(O_BUSY); endsequence
  sequence s_ctl_go; I_MODE_CTRL[*4] ##0 $rose(O_BUSY); endsequence
  ////////////////////////////////////////////////////////////////////////
  a_dark_when_busy: assert property (O_BUSY |-> O_RESULT_OE == 12'h000)
    else $error("lines enabled while busy");
  a_read_gate: assert property ((!I_RD_CONV || !I_CE || I_SEL_N)[*5] |-> O_RESULT_OE == 12'h000)
    else $error("lines enabled without read");
  a_byte_groups: assert property (O_RESULT_OE inside {12'h000, 12'hff0, 12'hfff})
    else $error("odd enable pattern");
  a_byte_no_low: assert property ((!I_WORD_WIDE)[*5] |-> O_RESULT_OE[3:0] == 4'h0)
    else $error("low lines enabled in byte mode");
  a_hold_in_busy: assert property (O_HOLD |-> O_BUSY)
    else $error("hold outside conversion");
  a_min_busy: assert property ($rose(O_BUSY) |-> O_BUSY[*8])
    else $error("conversion too short");
  a_busy_ends: assert property ($rose(O_BUSY) |-> ##[9:BUSY_HI] !O_BUSY)
    else $error("conversion too long");
  a_ctrl_hold: assert property (s_ctl_go |-> O_HOLD)
    else $error("no immediate hold");
  a_emu_wait: assert property (s_emu_go |-> !O_HOLD ##[EMU_LO:EMU_HI] $rose(O_HOLD))
    else $error("acquisition delay wrong");
  a_track_after: assert property ($fell(O_HOLD) |-> O_BUSY ##1 !O_BUSY)
    else $error("busy not dropped after latch");
endmodule
`default_nettype wire

// [dv/test_sar_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module test_sar_ctrl;
  logic clk = 0, rstn = 0, ce = 0, sel_n = 1, rd = 1, lbs = 0, ww = 1, mode = 1, lvl = 1;
  logic cmp, busy, hold;
  logic [11:0] lines, oe;
  int bad_count = 0, checked = 0, n;
  sar_ctrl #(.EMU_CYC(4)) i_sar_ctrl (.I_CLK(clk), .I_RSTN(rstn), .I_CE(ce), .I_SEL_N(sel_n),
    .I_RD_CONV(rd), .I_LENGTH_BYTE_SELECT(lbs), .I_WORD_WIDE(ww), .I_MODE_CTRL(mode),
    .I_CMP(cmp), .O_BUSY(busy), .O_HOLD(hold), .O_RESULT_LINES(lines), .O_RESULT_OE(oe));
  cmp_model i_cmp_model (.i_clk(clk), .i_level(lvl), .o_cmp(cmp));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic step(int k);
    repeat (k) @(posedge clk);
    #5;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // park two start inputs, move the third, then try a restart mid-run
  // relen is the length level offered with the ignored restart
  task automatic convert(logic md, logic len, int trig, int exp_len, logic relen);
    mode = md;
    lbs = len;
    ce = trig != 1;
    sel_n = trig == 2;
    rd = trig == 0;
    step(4); // parked well beyond 50ns
    case (trig)
      0: rd = 0;
      1: ce = 1;
      default: sel_n = 0;
    endcase
    n = 0;
    while (busy !== 1'b1 && n < 20) begin step(1); n++; end
    rd = 1;
    step(2);
    lbs = relen;
    rd = 0;
    n = 2;
    while (busy === 1'b1 && n < 100) begin step(1); n++; end
    `CHK("busy cycles", exp_len, n)
    rd = 1;
  endtask
  // only enabled lines carry meaning, the rest are masked off
  task automatic rd_chk(logic w, logic b, logic [11:0] eo, logic [11:0] ed);
    ww = w;
    lbs = b;
    step(6);
    `CHK("oe", eo, oe)
    `CHK("lines", ed, lines & oe)
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_ctrl_full();
    convert(1, 0, 0, 13, 0);
    rd_chk(1, 1, 12'hfff, 12'hfff);
    rd_chk(0, 0, 12'hff0, 12'hff0);
    rd_chk(0, 1, 12'hff0, 12'hf00);
    ce = 0;
    step(6);
    `CHK("oe off", 12'h000, oe)
    $display("test ctrl_full done");
  endtask
  task automatic t_ctrl_short();
    convert(1, 1, 1, 9, 1);
    rd_chk(1, 0, 12'hfff, 12'hff0);
    rd_chk(0, 1, 12'hff0, 12'h000);
    convert(1, 0, 0, 9, 1);
    rd_chk(1, 0, 12'hfff, 12'hff0);
    $display("test ctrl_short done");
  endtask
  task automatic t_emu();
    lvl = 0;
    convert(0, 0, 2, 17, 0);
    rd_chk(1, 0, 12'hfff, 12'h000);
    $display("test emu done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    #2000000;
    bad_count++;
    summarize();
  end
  initial begin
    step(16);
    rstn = 1;
    step(3);
    t_ctrl_full();
    t_ctrl_short();
    t_emu();
    summarize();
  end
endmodule
bind sar_ctrl sar_ctrl_chk #(.EMU_CYC(EMU_CYC)) i_sar_ctrl_chk (.I_CLK(I_CLK),
  .I_RSTN(I_RSTN), .I_CE(I_CE), .I_SEL_N(I_SEL_N), .I_RD_CONV(I_RD_CONV),
  .I_WORD_WIDE(I_WORD_WIDE), .I_MODE_CTRL(I_MODE_CTRL), .O_BUSY(O_BUSY),
  .O_HOLD(O_HOLD), .O_RESULT_OE(O_RESULT_OE));
`default_nettype wire

// [logic/sar_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
module sar_ctrl
  import sar_ctrl_pkg::*;
#(
  parameter int EMU_CYC = EMU_DELAY_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_CE,
  input wire logic I_SEL_N,
  input wire logic I_RD_CONV,
  input wire logic I_LENGTH_BYTE_SELECT,
  input wire logic I_WORD_WIDE,
  input wire logic I_MODE_CTRL,
  input wire logic I_CMP,
  output logic O_BUSY,
  output logic O_HOLD,
  output logic [RES_W-1:0] O_RESULT_LINES,
  output logic [RES_W-1:0] O_RESULT_OE
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage feeds only the second
  // the host drives these pins from its own timing, so every control level
  // passes two flops before any decode; this costs two cycles of start and
  // read latency, which stays far below the host's own setup windows
  // all control pins share one pipeline so levels that change together are seen
  // together, which keeps simultaneous start edges aligned

  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic [5:0] pins;
  logic cmp_meta_q;
  logic cmp_q;

  assign pins = {I_MODE_CTRL, I_WORD_WIDE, I_LENGTH_BYTE_SELECT, I_RD_CONV, I_SEL_N, I_CE};

  // control pin pipeline
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      meta_q <= 6'h00;
      sync_q <= 6'h00;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end

  // comparator pipeline; kept apart because its answer is analog in origin
  // and has no timing relation to the host pins
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      cmp_meta_q <= 1'b0;
      cmp_q <= 1'b0;
    end else begin
      cmp_meta_q <= I_CMP;
      cmp_q <= cmp_meta_q;
    end
  end

  logic ce_s;
  logic sel_n_s;
  logic rdc_s;
  logic lbs_s;
  logic wide_s;
  logic mode_ctrl_s;

  // live levels, nothing latched except the length input below
  assign ce_s = sync_q[0];
  assign sel_n_s = sync_q[1];
  assign rdc_s = sync_q[2];
  assign lbs_s = sync_q[3];
  assign wide_s = sync_q[4];
  assign mode_ctrl_s = sync_q[5];

  ////////////////////////////////////////////////////////////////////////////
  // start detection: rising edge of the combined start condition

  logic start_cond;
  logic start_cond_q;
  logic start_evt;

  // one AND of all three, so whichever input arrives last fires the same edge
  // and simultaneous changes see identical delay
  // the edge detector resets low, matching the synchronised idle levels, so
  // no false start follows reset; a host that already holds the start state
  // at release gets exactly one conversion once the pipeline has filled
  // limitation: a start pulse shorter than one clock period may be missed
  assign start_cond = ce_s & ~sel_n_s & ~rdc_s;

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      start_cond_q <= 1'b0;
    end else begin
      start_cond_q <= start_cond;
    end
  end

  assign start_evt = start_cond & ~start_cond_q;

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer

  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV, ST_LATCH} conv_state_e;

  conv_state_e state_q;
  logic short_q;
  logic [CNT_W-1:0] cnt_q;
  logic [RES_W-1:0] sar_q;
  logic [RES_W-1:0] trial;
  logic [RES_W-1:0] result_q;
  logic res_short_q;
  logic [3:0] bit_idx_q;

  // length captured on every start edge, also while busy
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      short_q <= 1'b0;
    end else if (start_evt) begin
      short_q <= lbs_s;
    end
  end

  // trial word with the bit under test set
  function automatic logic [RES_W-1:0] set_bit(input logic [RES_W-1:0] w, input logic [3:0] i);
    logic [RES_W-1:0] r;
    r = w;
    r[i] = 1'b1;
    return r;
  endfunction

  assign trial = set_bit(sar_q, bit_idx_q);

  // last count of the bit phase; the length is read live so a recapture
  // during busy still shortens or stretches the running conversion
  function automatic logic [CNT_W-1:0] last_bit_cnt(input logic short_len);
    logic [CNT_W-1:0] r;
    r = short_len ? CNT_W'(BITS_SHORT - 1) : CNT_W'(BITS_FULL - 1);
    return r;
  endfunction

  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [3:0] IDX_ONE = 4'h1;
  localparam logic [3:0] IDX_TOP = 4'(RES_W - 1);

  logic acq_done;
  logic conv_done;
  logic go;

  // a start is only honoured in idle, so a running conversion cannot be restarted
  // by the three start inputs, though a start edge while busy still recaptures its length
  assign go = (state_q == ST_IDLE) & start_evt;
  assign acq_done = (state_q == ST_ACQ) & (cnt_q == CNT_W'(EMU_CYC - 1));
  assign conv_done = (state_q == ST_CONV) & (cnt_q == last_bit_cnt(short_q));

  // sequence timing, counted in clock edges after the start edge is seen:
  //   control mode: idle -> conv at once, hold rises with busy
  //   emulation mode: idle -> acq for EMU_CYC edges while the sample/hold
  //   keeps tracking, then conv
  //   conv lasts 12 or 8 edges, one bit decided per edge, msb first
  //   latch takes one edge; busy falls on that same edge
  // the acquisition wait trades aperture delay for drop-in timing: the
  // input only has to settle by the end of acq, not before the command

  // state register
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (go) begin
            if (mode_ctrl_s) begin
              state_q <= ST_CONV;
            end else begin
              state_q <= ST_ACQ;
            end
          end
        end
        ST_ACQ: begin
          if (acq_done) begin
            state_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            state_q <= ST_LATCH;
          end
        end
        ST_LATCH: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // one counter serves both the acquisition wait and the bit phase; it is
  // cleared at every phase boundary so each phase counts from zero
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      cnt_q <= CNT_ZERO;
    end else if (go || acq_done || conv_done) begin
      cnt_q <= CNT_ZERO;
    end else if (state_q == ST_ACQ || state_q == ST_CONV) begin
      cnt_q <= cnt_q + CNT_ONE;
    end
  end

  // successive approximation register; the comparator keeps or drops the
  // trial bit of the current decision
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      sar_q <= RES_RST;
    end else if (go) begin
      sar_q <= RES_RST;
    end else if (state_q == ST_CONV) begin
      sar_q <= cmp_q ? trial : sar_q;
    end
  end

  // bit pointer walks from the msb down, one place per decision
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      bit_idx_q <= 4'h0;
    end else if (go) begin
      bit_idx_q <= IDX_TOP;
    end else if (state_q == ST_CONV && !conv_done) begin
      bit_idx_q <= bit_idx_q - IDX_ONE;
    end
  end

  // result latch, loaded on the edge that ends latch state, as busy falls
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      result_q <= RES_RST;
      res_short_q <= 1'b0;
    end else if (state_q == ST_LATCH) begin
      result_q <= sar_q;
      res_short_q <= short_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // busy and sample/hold

  // busy covers latch state so it falls on the same edge that stores the result
  assign O_BUSY = (state_q != ST_IDLE);
  // hold only while bits are decided; tracking resumes in latch state
  // and throughout emulation acquisition
  assign O_HOLD = (state_q == ST_CONV);

  ////////////////////////////////////////////////////////////////////////////
  // output data and enables

  logic rd_ok;
  logic [RES_W-1:0] word;
  logic [RES_W-1:0] oe_d;
  logic [RES_W-1:0] data_d;
  logic [RES_W-1:0] oe_q;
  logic [RES_W-1:0] data_q;

  // short conversion leaves the low nibble unresolved: force zeros
  assign word = res_short_q ? {result_q[RES_W-1:LSB_NIB], NIB_ZERO} : result_q;

  // read path: enables follow the live pin levels with two synchroniser
  // stages plus one output register, so a host sees data about three
  // cycles after it sets up a read
  // the upper eight lines are shared by both bytes; lines 3..0 are only
  // ever driven in word mode, so an 8-bit bus tied to the upper group can
  // never see two drivers however byte-select toggles
  // limitation: a byte-select change mid-read shows the other byte after
  // the same three-cycle latency, with enables never overlapping
  // byte-select is read live here, never the captured copy
  assign rd_ok = rdc_s & ~O_BUSY & ce_s & ~sel_n_s;

  always_comb begin
    oe_d = RES_RST;
    data_d = RES_RST;
    if (rd_ok) begin
      if (wide_s) begin
        oe_d = {RES_W{1'b1}};
        data_d = word;
      end else if (!lbs_s) begin
        oe_d = {{(RES_W-LSB_NIB){1'b1}}, NIB_ZERO};
        data_d = {word[RES_W-1:LSB_NIB], NIB_ZERO};
      end else begin
        // upper group carries the low nibble and forced zeros; lines 3..0 stay off
        oe_d = {{(RES_W-LSB_NIB){1'b1}}, NIB_ZERO};
        data_d = {word[LSB_NIB-1:0], NIB_ZERO, NIB_ZERO};
      end
    end
  end

  // registered outputs; costs one cycle of enable delay but avoids glitches
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      oe_q <= RES_RST;
      data_q <= RES_RST;
    end else begin
      oe_q <= oe_d;
      data_q <= data_d;
    end
  end

  assign O_RESULT_OE = oe_q & {RES_W{~O_BUSY}};
  assign O_RESULT_LINES = data_q;

endmodule
`default_nettype wire

// [logic/sar_ctrl_pkg.sv]
package sar_ctrl_pkg;
  // result width and short-cycle length
  localparam int RES_W = 12;
  localparam int BITS_FULL = 12;
  localparam int BITS_SHORT = 8;
  localparam int LSB_NIB = 4;
  // clock rate and emulation acquisition delay
  localparam int CLK_PERIOD_NS = 50;
  localparam int EMU_DELAY_NS = 1600;
  localparam int EMU_DELAY_CYC = (EMU_DELAY_NS / CLK_PERIOD_NS) > 0 ?
                                 (EMU_DELAY_NS / CLK_PERIOD_NS) : 1;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [RES_W-1:0] RES_RST = 12'h000;
  localparam logic [3:0] NIB_ZERO = 4'h0;
endpackage
